// ===== logic/panel_defines.svh
`ifndef PANEL_DEFINES_SVH
`define PANEL_DEFINES_SVH

// clock and refresh timing
`define REF_CLK_HZ 100000000
`define REFRESH_OSC_HZ 3500
`define REFRESH_DIV_CYCLES (`REF_CLK_HZ / `REFRESH_OSC_HZ)
`define DIGIT_COUNT 5'h18
`define RAM_DEPTH 128

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_LOAD 8'h04
`define OFS_RAM_RDATA 8'h08
`define OFS_KEY_STATUS 8'h0c
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14
`define OFS_REFRESH_POS 8'h18

// reset values and response codes
`define CTRL_RESET 5'h03
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// ===== logic/panel_pkg.sv
`include "panel_defines.svh"
package panel_pkg;

  // axi4-lite master to slave
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axi_req_t;

  // axi4-lite slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

  // control port: bank bits, drive enable, r/w, clear
  typedef struct packed {
    logic [1:0] bank_sel;
    logic cnt_drive_n;
    logic ram_rw;
    logic latch_clear_bit;
  } ctrl_t;

  // load port: write strobe, location, data
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } load_t;

  // keypad status byte
  typedef struct packed {
    logic jog_live;
    logic first_q;
    logic second_q;
    logic third_q;
    logic [3:0] code;
  } key_status_t;

  // bank latch module state
  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] prev;
    logic [2:0] latch;
    logic irq_n;
  } key_state_t;

  // main module state
  typedef struct packed {
    ctrl_t ctrl;
    load_t load;
    logic [1:0] irq_st;
    logic [1:0] irq_mask;
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] osc_cnt;
    logic [4:0] refresh_cnt;
    logic [7:0] seg_byte;
    logic [23:0] cath_n;
    key_status_t key_status;
    logic [`RAM_DEPTH-1:0][7:0] ram;
  } main_state_t;

endpackage : panel_pkg

// ===== logic/key_bank_latches.sv
`timescale 1ns/10ps
`include "panel_defines.svh"
// three keypad bank latches with shared clear
module key_bank_latches (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // bank lines: 0 first, 1 jog, 2 third
  input wire logic [2:0] i_avail,
  input wire logic i_clear_n,
  // latch state and decoder enables
  output logic [2:0] o_latch,
  output logic [2:0] o_enable_n,
  output logic o_irq_n,
  output logic o_jog_live,
  output logic o_key_event
);

  panel_pkg::key_state_t q; // registered state
  panel_pkg::key_state_t d; // next state
  logic [2:0] edge_w; // new press per bank

  // rising edges seen after the second stage only
  assign edge_w = q.sync2 & ~q.prev;

  // next state
  always_comb
  begin
    d = q;
    d.sync1 = i_avail;
    d.sync2 = q.sync1;
    d.prev = q.sync2;
    // one clear empties all three together
    if (!i_clear_n)
    begin
      d.latch = 3'h0;
    end
    // set beats clear so a press is never lost
    d.latch = d.latch | edge_w;
    d.irq_n = ~(|d.latch);
  end

  // state register
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      q <= '0;
      q.irq_n <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign o_latch = q.latch;
  assign o_enable_n = ~q.latch;
  assign o_irq_n = q.irq_n;
  assign o_jog_live = q.sync2[1];
  assign o_key_event = |edge_w;

  sequence s_first_press;
    $rose(i_avail[0]) ##1 i_avail[0];
  endsequence

  a_first_sets_latch: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    s_first_press |-> ##2 o_latch[0])
    else $error("first bank press did not set its latch");
  a_clear_all_banks: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    !i_clear_n && !(|edge_w) |=> o_latch == 3'h0)
    else $error("clear left a bank latch set");
  a_irq_on_press: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    |edge_w |=> !o_irq_n && o_enable_n != 3'h7)
    else $error("press did not raise keypad interrupt");
  a_irq_needs_edge: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $fell(o_irq_n) |-> $past(o_key_event))
    else $error("keypad interrupt asserted without a press");
  a_irq_drops_clear: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $rose(o_irq_n) |-> $past(i_clear_n) == 1'b0)
    else $error("keypad interrupt dropped without clear");

endmodule : key_bank_latches

// ===== logic/led_refresh_keypad_interface.sv
`timescale 1ns/10ps
`include "panel_defines.svh"
// front panel led refresh and keypad interface
module led_refresh_keypad_interface #(
  // cycles per refresh tick
  parameter int unsigned OSC_DIV = `REFRESH_DIV_CYCLES
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // register bus
  input wire panel_pkg::axi_req_t i_axi_req,
  output panel_pkg::axi_rsp_t o_axi_rsp,
  output logic o_irq,
  // led panel
  output logic [6:0] o_seg,
  output logic o_decimal_point_line,
  output logic [23:0] o_digit_cathode_n,
  // keypad decoder board
  input wire logic [3:0] i_key_code_lines,
  input wire logic i_bank_one_available,
  input wire logic i_jog_bank_available,
  input wire logic i_bank_three_available,
  output logic [2:0] o_bank_enable_n,
  output logic o_keypad_irq_probe_n
);

  panel_pkg::main_state_t q; // registered state
  panel_pkg::main_state_t d; // next state

  logic [2:0] latch_w; // bank latch outputs
  logic jog_live_w; // synced jog line
  logic key_event_w; // one-cycle new press
  logic awready_w; // write address ready
  logic wready_w; // write data ready
  logic arready_w; // read address ready
  logic tick_w; // refresh oscillator pulse
  logic wrap_w; // last digit reached on tick
  logic ram_we_w; // load port write this cycle
  logic [7:0] ref_byte_w; // byte under refresh address

  // merge a bus word into an old value by byte lane
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  // keypad bank latches
  key_bank_latches u_latches (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_avail({i_bank_three_available, i_jog_bank_available, i_bank_one_available}),
    .i_clear_n(q.ctrl.latch_clear_bit),
    .o_latch(latch_w),
    .o_enable_n(o_bank_enable_n),
    .o_irq_n(o_keypad_irq_probe_n),
    .o_jog_live(jog_live_w),
    .o_key_event(key_event_w)
  );

  // bus handshakes: one write and one read in flight
  assign awready_w = !q.aw_have && !q.bvalid;
  assign wready_w = !q.w_have && !q.bvalid;
  assign arready_w = !q.rvalid;

  // oscillator and divide-by-24 sweep
  assign tick_w = (q.osc_cnt == 16'(OSC_DIV - 1));
  assign wrap_w = tick_w && (q.refresh_cnt == `DIGIT_COUNT - 5'h01);

  // the refresh buffer only drives while enable is low
  assign ref_byte_w = q.ram[{q.ctrl.bank_sel, q.refresh_cnt}];

  // load port writes only with buffer off and write mode
  assign ram_we_w = q.load.wr && q.ctrl.cnt_drive_n && !q.ctrl.ram_rw;

  // next state
  always_comb
  begin
    logic [31:0] wv;
    wv = '0;
    d = q;
    d.load.wr = 1'b0;

    // address and data may arrive in either order
    if (i_axi_req.awvalid && awready_w)
    begin
      d.aw_have = 1'b1;
      d.awaddr = i_axi_req.awaddr;
    end
    if (i_axi_req.wvalid && wready_w)
    begin
      d.w_have = 1'b1;
      d.wdata = i_axi_req.wdata;
      d.wstrb = i_axi_req.wstrb;
    end

    // perform the write once both halves are held
    if (q.aw_have && q.w_have)
    begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `RESP_OKAY;
      case (q.awaddr)
        `OFS_CTRL:
        begin
          // bank bits, drive enable, r/w, clear
          wv = merge_bytes(32'(q.ctrl), q.wdata, q.wstrb);
          d.ctrl = panel_pkg::ctrl_t'(wv[4:0]);
        end
        `OFS_LOAD:
        begin
          // data, location and strobe in one word
          wv = merge_bytes(32'(q.load), q.wdata, q.wstrb);
          d.load = panel_pkg::load_t'(wv[15:0]);
        end
        `OFS_IRQ_STATUS:
        begin
          // write one to clear
          wv = merge_bytes(32'h0, q.wdata, q.wstrb);
          d.irq_st = q.irq_st & ~wv[1:0];
        end
        `OFS_IRQ_MASK:
        begin
          wv = merge_bytes(32'(q.irq_mask), q.wdata, q.wstrb);
          d.irq_mask = wv[1:0];
        end
        default:
        begin
          // read-only or unmapped: nothing stored
          d.bresp = (q.awaddr == `OFS_RAM_RDATA || q.awaddr == `OFS_KEY_STATUS
            || q.awaddr == `OFS_REFRESH_POS) ? `RESP_OKAY : `RESP_DECERR;
        end
      endcase
    end
    if (q.bvalid && i_axi_req.bready)
    begin
      d.bvalid = 1'b0;
    end

    // read: answer one cycle after the address
    if (q.rvalid && i_axi_req.rready)
    begin
      d.rvalid = 1'b0;
    end
    if (i_axi_req.arvalid && arready_w)
    begin
      d.rvalid = 1'b1;
      d.rresp = `RESP_OKAY;
      d.rdata = 32'h0;
      case (i_axi_req.araddr)
        `OFS_CTRL:
        begin
          d.rdata = 32'(q.ctrl);
        end
        `OFS_LOAD:
        begin
          d.rdata = 32'(q.load);
        end
        `OFS_RAM_RDATA:
        begin
          // the ram only answers in read mode
          if (q.ctrl.ram_rw)
          begin
            d.rdata = 32'(q.ram[q.load.addr]);
          end
        end
        `OFS_KEY_STATUS:
        begin
          d.rdata = 32'(q.key_status);
        end
        `OFS_IRQ_STATUS:
        begin
          d.rdata = 32'(q.irq_st);
        end
        `OFS_IRQ_MASK:
        begin
          d.rdata = 32'(q.irq_mask);
        end
        `OFS_REFRESH_POS:
        begin
          d.rdata = 32'({q.ctrl.bank_sel, q.refresh_cnt});
        end
        default:
        begin
          d.rresp = `RESP_DECERR;
        end
      endcase
    end

    // load port write into the display ram
    if (ram_we_w)
    begin
      d.ram[q.load.addr] = q.load.data;
    end

    // free-running oscillator, never stopped by loading
    if (tick_w)
    begin
      d.osc_cnt = 16'h0;
      // sweep 0..23 then wrap, keeps cycling forever
      if (wrap_w)
      begin
        d.refresh_cnt = 5'h0;
      end
      else
      begin
        d.refresh_cnt = q.refresh_cnt + 5'h01;
      end
    end
    else
    begin
      d.osc_cnt = q.osc_cnt + 16'h0001;
    end

    // panel drive: one cathode at a time on shared segments
    if (!q.ctrl.cnt_drive_n)
    begin
      d.seg_byte = ref_byte_w;
      d.cath_n = ~(24'h00_0001 << q.refresh_cnt);
    end
    else
    begin
      // buffer floated: panel dark while cpu loads
      d.seg_byte = 8'h00;
      d.cath_n = '1;
    end

    // status byte, bit 7 taken live from jog line
    d.key_status.jog_live = jog_live_w;
    d.key_status.first_q = latch_w[0];
    d.key_status.second_q = latch_w[1];
    d.key_status.third_q = latch_w[2];
    d.key_status.code = i_key_code_lines;

    // sticky events: set wins over a same-cycle clear
    d.irq_st = d.irq_st | {wrap_w, key_event_w};
  end

  // state register
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      q <= '0;
      q.ctrl <= panel_pkg::ctrl_t'(`CTRL_RESET);
      q.cath_n <= '1;
    end
    else
    begin
      q <= d;
    end
  end

  // bus outputs
  always_comb
  begin
    o_axi_rsp.awready = awready_w;
    o_axi_rsp.wready = wready_w;
    o_axi_rsp.bvalid = q.bvalid;
    o_axi_rsp.bresp = q.bresp;
    o_axi_rsp.arready = arready_w;
    o_axi_rsp.rvalid = q.rvalid;
    o_axi_rsp.rdata = q.rdata;
    o_axi_rsp.rresp = q.rresp;
  end

  // panel and interrupt outputs
  assign o_seg = q.seg_byte[6:0];
  assign o_decimal_point_line = q.seg_byte[7];
  assign o_digit_cathode_n = q.cath_n;
  assign o_irq = |(q.irq_st & q.irq_mask);

  sequence s_driving;
    !q.ctrl.cnt_drive_n;
  endsequence

  a_refresh_range: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    q.refresh_cnt < `DIGIT_COUNT)
    else $error("refresh counter left the 24 digits");
  a_refresh_wrap: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    wrap_w |=> q.refresh_cnt == 5'h0 ##1 q.refresh_cnt == 5'h0)
    else $error("refresh counter did not wrap to zero");
  a_seg_from_bank: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    s_driving |=> {o_decimal_point_line, o_seg} == $past(ref_byte_w))
    else $error("segments do not show the selected bank");
  a_one_digit_lit: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    s_driving |=> $onehot(~o_digit_cathode_n))
    else $error("not exactly one cathode on");
  a_float_blanks: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    q.ctrl.cnt_drive_n |=> o_digit_cathode_n == 24'hff_ffff)
    else $error("panel lit while refresh buffer floated");
  a_ram_write_mode: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    ram_we_w |=> q.ram[$past(q.load.addr)] == $past(q.load.data))
    else $error("load port write did not reach the ram");
  a_status_jog_bit: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    ##1 q.key_status.jog_live == $past(jog_live_w) && q.key_status.first_q == $past(latch_w[0]))
    else $error("status byte does not follow latches");

endmodule : led_refresh_keypad_interface

// ===== sim/keypad_decoder_model.sv
`timescale 1ns/10ps
// keypad decoder board stand-in
module keypad_decoder_model (
  // clock
  input wire logic i_ref_clk,
  // bank code enables from the panel
  input wire logic [2:0] i_bank_enable_n,
  // key code and bank lines
  output logic [3:0] o_key_code_lines,
  output logic [2:0] o_avail
);
  logic [3:0] code_q; // code of the held key
  logic [1:0] bank_q; // bank of the held key

  // quiet lines at time zero
  initial
  begin
    o_avail = 3'h0;
    code_q = 4'h0;
    bank_q = 2'h0;
    o_key_code_lines = 4'h0;
  end

  // code only while its bank is enabled; otherwise a toggling pattern
  // so that a stale code can never pass for a fresh one
  always @(posedge i_ref_clk)
  begin
    if (!i_bank_enable_n[bank_q])
      o_key_code_lines <= code_q;
    else
      o_key_code_lines <= ~o_key_code_lines;
  end

  // press a key: code plus one bank line
  task automatic press(input logic [1:0] b, input logic [3:0] c);
    @(posedge i_ref_clk);
    code_q <= c;
    bank_q <= b;
    o_avail <= 3'h1 << b;
  endtask : press

  // release the key, all bank lines low
  task automatic let_go;
    @(posedge i_ref_clk);
    o_avail <= 3'h0;
  endtask : let_go
endmodule : keypad_decoder_model

// ===== sim/tb_led_refresh_keypad_interface.sv
`timescale 1ns/10ps
`include "panel_defines.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
// bench for the front panel block
module tb_led_refresh_keypad_interface;
  logic ref_clk; // 100 MHz
  logic arst_n; // async reset
  panel_pkg::axi_req_t req; // bus requests
  panel_pkg::axi_rsp_t rsp; // bus answers
  logic irq, dp, kirq_n; // interrupts and dot
  logic [6:0] seg; // segment lines
  logic [23:0] cath_n; // digit cathodes
  logic [2:0] en_n, avail; // bank enables and lines
  logic [3:0] code; // key code lines
  logic [7:0] exp_ram [128]; // expected ram image
  logic [33:0] q [$]; // expected read and write answers
  int fail_count, checked, i;
  logic [3:0] c;

  led_refresh_keypad_interface #(.OSC_DIV(4)) i_dut (
    .i_ref_clk(ref_clk), .i_arst_n(arst_n), .i_axi_req(req), .o_axi_rsp(rsp),
    .o_irq(irq), .o_seg(seg), .o_decimal_point_line(dp), .o_digit_cathode_n(cath_n),
    .i_key_code_lines(code), .i_bank_one_available(avail[0]),
    .i_jog_bank_available(avail[1]), .i_bank_three_available(avail[2]),
    .o_bank_enable_n(en_n), .o_keypad_irq_probe_n(kirq_n));

  keypad_decoder_model i_pad (.i_ref_clk(ref_clk), .i_bank_enable_n(en_n),
    .o_key_code_lines(code), .o_avail(avail));

  // free running clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // verdict and end of run
  task automatic finish_test;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  // bounded wait ran out
  task automatic hang;
    fail_count++;
    finish_test();
  endtask : hang

  // one write; readies sampled at negedge, released at the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ta, tw, tb, busy;
    // unaligned or past the last register is refused
    q.push_back({(a[1:0] != 2'h0 || a > `OFS_REFRESH_POS) ? `RESP_DECERR : `RESP_OKAY, 32'h0});
    @(posedge ref_clk);
    req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1;
    req.wdata <= d; req.wstrb <= 4'hf; req.bready <= 1'b1;
    busy = 1'b1;
    for (n = 0; busy; n++)
    begin
      @(negedge ref_clk);
      ta = req.awvalid && rsp.awready;
      tw = req.wvalid && rsp.wready;
      tb = rsp.bvalid && req.bready;
      @(posedge ref_clk);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
      if (tb) begin req.bready <= 1'b0; busy = 1'b0; end
      if (n > 50) hang();
    end
  endtask : wr

  // one read; the expected answer goes on the queue first
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    logic ta, tr, busy;
    q.push_back(e);
    @(posedge ref_clk);
    req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
    busy = 1'b1;
    for (n = 0; busy; n++)
    begin
      @(negedge ref_clk);
      ta = req.arvalid && rsp.arready;
      tr = rsp.rvalid && req.rready;
      @(posedge ref_clk);
      if (ta) req.arvalid <= 1'b0;
      if (tr) begin req.rready <= 1'b0; busy = 1'b0; end
      if (n > 50) hang();
    end
  endtask : rd

  // watcher: every read answer against the oldest note
  always @(negedge ref_clk)
  begin
    if (rsp.rvalid && req.rready)
      `CHK({rsp.rresp, rsp.rdata}, q.pop_front())
    // write responses share the queue; only one transfer is ever open
    if (rsp.bvalid && req.bready)
      `CHK({rsp.bresp, 32'h0}, q.pop_front())
  end

  // watch two frames of one bank on the panel
  task automatic scan(input int bank);
    logic [23:0] seen;
    int k, idx;
    seen = 24'h0;
    repeat (4) @(negedge ref_clk);
    repeat (192)
    begin
      @(negedge ref_clk);
      idx = -1;
      for (k = 23; k >= 0; k--) if (cath_n[k] === 1'b0) idx = k;
      if (idx >= 0)
      begin
        `CHK(cath_n, ~(24'h1 << idx))
        `CHK({dp, seg}, exp_ram[bank * 32 + idx])
        seen[idx] = 1'b1;
      end
    end
    `CHK(seen, 24'hffffff)
  endtask : scan

  // main sequence
  initial
  begin
    arst_n = 1'b0; req = '0; fail_count = 0; checked = 0;
    void'($urandom(32'he1491c68));
    for (i = 0; i < 128; i++) exp_ram[i] = 8'h00;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(`OFS_CTRL, {`RESP_OKAY, 27'h0, `CTRL_RESET});
    rd(`OFS_IRQ_MASK, {`RESP_OKAY, 32'h0});
    rd(8'h40, {`RESP_DECERR, 32'h0});
    wr(8'h41, 32'h0);
    // load bank 0 with the panel dark; bank 1 stays zeros for flashing
    wr(`OFS_CTRL, 32'h5);
    @(negedge ref_clk);
    `CHK(cath_n, 24'hffffff)
    for (i = 0; i < 24; i++)
    begin
      exp_ram[i] = 8'($urandom);
      wr(`OFS_LOAD, {16'h0, 1'b1, 7'(i), exp_ram[i]});
    end
    exp_ram[127] = 8'($urandom);
    wr(`OFS_LOAD, {16'h0, 1'b1, 7'd127, exp_ram[127]});
    wr(`OFS_CTRL, 32'h7);
    wr(`OFS_LOAD, {16'h0, 1'b0, 7'd127, 8'h0});
    rd(`OFS_RAM_RDATA, {`RESP_OKAY, 24'h0, exp_ram[127]});
    // refresh from bank 0, then the blank bank
    wr(`OFS_CTRL, 32'h3);
    scan(0);
    wr(`OFS_CTRL, 32'hb);
    scan(1);
    wr(`OFS_CTRL, 32'h3);
    // one key in each bank
    for (i = 0; i < 3; i++)
    begin
      c = 4'($urandom);
      i_pad.press(2'(i), c);
      for (int n = 0; kirq_n !== 1'b0; n++)
      begin
        @(negedge ref_clk);
        if (n > 20) hang();
      end
      `CHK(en_n, ~(3'h1 << i))
      // decoder answers the enable a cycle later, status lags once more
      repeat (2) @(negedge ref_clk);
      rd(`OFS_KEY_STATUS, {`RESP_OKAY, 24'h0, i == 1, 3'h4 >> i, c});
      i_pad.let_go();
      repeat (4) @(posedge ref_clk);
      rd(`OFS_KEY_STATUS, {`RESP_OKAY, 24'h0, 1'b0, 3'h4 >> i, c});
      if (i == 0)
      begin
        wr(`OFS_IRQ_MASK, 32'h1);
        repeat (2) @(negedge ref_clk);
        `CHK(irq, 1'b1)
        wr(`OFS_IRQ_STATUS, 32'h1);
        repeat (2) @(negedge ref_clk);
        `CHK(irq, 1'b0)
      end
      wr(`OFS_CTRL, 32'h2);
      wr(`OFS_CTRL, 32'h3);
      repeat (2) @(negedge ref_clk);
      `CHK(en_n, 3'h7)
      `CHK(kirq_n, 1'b1)
    end
    // frame wrap raises the interrupt once unmasked
    wr(`OFS_IRQ_MASK, 32'h2);
    // drop the stale wrap so the next one must come from the sweep
    wr(`OFS_IRQ_STATUS, 32'h2);
    for (int n = 0; irq !== 1'b1; n++)
    begin
      @(negedge ref_clk);
      if (n > 300) hang();
    end
    `CHK(irq, 1'b1)
    // counter sits on digit 0 of bank 0 right after the wrap
    rd(`OFS_REFRESH_POS, {`RESP_OKAY, 32'h0});
    finish_test();
  end
endmodule : tb_led_refresh_keypad_interface
